/* rtl/lp_mode_defs.vh */
// Constants for the low-power mode controller
`ifndef LP_MODE_DEFS_VH
`define LP_MODE_DEFS_VH

// Register offsets
`define REG_MODE_SEL 4'h0
`define REG_RET_CFG 4'h1
`define REG_GATE_CFG 4'h2
`define REG_SRAM_PWR 4'h3
`define REG_STATUS 4'h4
`define REG_WAKE_SRC 4'h5
`define REG_IO_RET 4'h6
`define REG_IO_RET_HI 4'h7
`define REG_WAKE_HI 4'h8

// Mode encodings
`define MODE_RUN 3'h0
`define MODE_SLEEP 3'h1
`define MODE_STOP0 3'h2
`define MODE_STOP1 3'h3
`define MODE_STOP2 3'h4
`define MODE_STBY_RET 3'h5
`define MODE_STBY 3'h6
`define MODE_RESET 3'h7

// Retention config field positions
`define RET_SRAM1_BIT 0
`define RET_SRAM2_BIT 1
`define RET_RADIO_BIT 2
`define RET_BOR_ULP_BIT 3
`define RET_WK_POL_BIT 4

// Gate config field positions
`define GATE_SRAM1_BIT 0
`define GATE_SRAM2_BIT 1
`define GATE_FLASH_BIT 2

// Wake source indices
`define WK_RESET_PIN 0
`define WK_IO 1
`define WK_BOR 2
`define WK_PVD 3
`define WK_RTC 4
`define WK_TAMPER_UNIT 5
`define WK_INDEPENDENT_WATCHDOG 6
`define WK_RSC 7
`define WK_SERIAL1 8
`define WK_SERIAL_PERIPHERAL_THREE 9
`define WK_TWO3 10
`define WK_TIM1 11
`define WK_OTHER 12
`define WK_PIN 13
`define WK_COUNT 14

// System clock source encodings
`define CLK_RC16 2'h0
`define CLK_XTAL32 2'h1
`define CLK_PLL 2'h2

// Reset counter load after standby exit; the reset sequence runs one cycle longer
`define STBY_RST_CYCLES 4'h8

`endif

/* rtl/wake_sync.v */
// Two-stage synchroniser for a vector of asynchronous inputs
module wake_sync #(
    parameter WIDTH = 14
) (
    // Clock and reset
    input wire clk_in,
    input wire rstn_in,
    // Data
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate
    assign sync_out = stage2;
endmodule // wake_sync

/* rtl/low_power_mode_controller.v */
// Low-power mode sequencer with register port
//
// Implementation choices: the address map and the plain strobed port.
`include "lp_mode_defs.vh"

// Behaviour
// RULE1 - After reset the device is in Run; software then picks a mode.
// RULE2 - Sleep halts only the processor clock; any interrupt or event wakes it.
// RULE3 - Stop 0/1 stop core clocks, PLL and fast oscillators; retain state; slow osc runs.
// RULE4 - Stop bus clock requests use the 16 MHz RC; DMA needs move to Stop 0.
// RULE5 - Stop 0 keeps main regulator; Stop 1, 2, standby retention use low-power regulator.
// RULE6 - Leaving any Stop or Standby mode selects the 16 MHz RC as system clock.
// RULE7 - Stop 2 keeps only the listed peripherals powered; others are off.
// RULE8 - Stop 2 exits on reset pin, I/O or listed peripheral wake sources.
// RULE9 - Standby powers off core domain, PLL, fast oscillators; slow osc keeps running.
// RULE10 - Brownout monitor stays active throughout Standby and cannot be disabled.
// RULE11 - Selected SRAM retention keeps SRAM1/SRAM2 during Standby on low-power regulator.
// RULE12 - Selected radio retention keeps radio state during Standby on low-power regulator.
// RULE13 - Standby exits on reset pin, watchdog, wake pin edge, RTC or tamper.
// RULE14 - Radio sleep counter wakes Standby only with radio retention.
// RULE15 - In Standby each I/O holds its configured pull-up, pull-down or floating state.
// RULE16 - Brownout ultra-low-power setting applies in Stop 1, Stop 2 and Standby.
// RULE17 - Stop 0 turns the 16 MHz RC on while a peripheral requests it.
// RULE18 - Stop 0 keeps autonomous DMA peripherals clocked and accepts their wake interrupts.
// RULE19 - Stop 1/2 peripherals may issue bus clock requests or wake interrupts.
// RULE20 - Flash may be powered down while running from SRAM; SRAM clocks gate separately.
// RULE21 - In Stop and standby retention each SRAM can be powered off individually.
// RULE22 - Stop or Sleep wake returns to Run; Standby wake passes through reset first.
module low_power_mode_controller (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Register port
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // Processor handshake
    input wire cpu_lp_entry_in,
    input wire cpu_irq_in,
    // Wake sources, asynchronous
    input wire [`WK_COUNT-1:0] wake_src_in,
    // Peripheral clock requests, asynchronous
    input wire stop_busclk_req_in,
    input wire stop_dma_req_in,
    // Clock controls
    output reg cpu_clk_en_out,
    output reg core_clk_en_out,
    output reg pll_en_out,
    output reg internal_16mhz_rc_en_out,
    output reg crystal_32mhz_osc_en_out,
    output reg slow_osc_en_out,
    output reg [1:0] sysclk_sel_out,
    output reg sram1_clk_en_out,
    output reg sram2_clk_en_out,
    output reg flash_clk_en_out,
    output reg flash_pwr_en_out,
    // Power controls
    output reg main_reg_en_out,
    output reg low_power_regulator_state_out,
    output reg core_domain_pwr_out,
    output reg sram1_pwr_out,
    output reg sram2_pwr_out,
    output reg radio_ret_out,
    output reg periph_all_pwr_out,
    output reg periph_stop2_pwr_out,
    output reg brownout_reset_en_out,
    output reg brownout_reset_ulp_out,
    output reg io_retain_out,
    output reg [15:0] io_ret_cfg_out,
    output reg system_reset_out,
    output reg [2:0] mode_out
);
    localparam ST_RUN = 3'h0;
    localparam ST_SLEEP = 3'h1;
    localparam ST_STOP0 = 3'h2;
    localparam ST_STOP1 = 3'h3;
    localparam ST_STOP2 = 3'h4;
    localparam ST_STBY_RET = 3'h5;
    localparam ST_STBY = 3'h6;
    localparam ST_RESET = 3'h7;

    reg rst_s1;
    reg rst_n;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [2:0] mode_sel;
    reg [4:0] ret_cfg;
    reg [2:0] gate_cfg;
    reg [1:0] sram_off;
    reg [15:0] io_ret;
    reg [`WK_COUNT-1:0] wake_seen;
    reg [`WK_COUNT-1:0] wake_prev;
    reg [3:0] rst_cnt;
    reg stop1_parked;
    reg wake_now;
    reg [7:0] next_rdata;
    wire [`WK_COUNT-1:0] wake_s;
    wire [1:0] clkreq_s;
    wire pin_edge;
    wire [`WK_COUNT-1:0] stop2_mask;
    wire [`WK_COUNT-1:0] stby_mask;

    // Reset release through two flops
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    wake_sync #(.WIDTH(`WK_COUNT)) u_wake_sync (
        .clk_in(sys_clk_in),
        .rstn_in(rst_n),
        .async_in(wake_src_in),
        .sync_out(wake_s)
    );

    wake_sync #(.WIDTH(2)) u_req_sync (
        .clk_in(sys_clk_in),
        .rstn_in(rst_n),
        .async_in({stop_dma_req_in, stop_busclk_req_in}),
        .sync_out(clkreq_s)
    );

    // Edge on wake pin with programmable polarity [RULE13]
    assign pin_edge = ret_cfg[`RET_WK_POL_BIT] ?
        (wake_prev[`WK_PIN] & ~wake_s[`WK_PIN]) :
        (~wake_prev[`WK_PIN] & wake_s[`WK_PIN]);

    // Stop 2 wake set: everything but generic sources and the wake pin [RULE8]
    assign stop2_mask = {`WK_COUNT{1'b1}} & ~(14'h1 << `WK_OTHER) & ~(14'h1 << `WK_PIN);

    // Standby wake set; sleep counter only with radio retention [RULE13] [RULE14]
    assign stby_mask = (14'h1 << `WK_RESET_PIN) | (14'h1 << `WK_BOR) |
        (14'h1 << `WK_RTC) | (14'h1 << `WK_TAMPER_UNIT) | (14'h1 << `WK_INDEPENDENT_WATCHDOG) |
        ((state == ST_STBY_RET && ret_cfg[`RET_RADIO_BIT]) ? (14'h1 << `WK_RSC) : 14'h0);

    always @* begin
        wake_now = 1'b0;
        case (state)
            ST_SLEEP: wake_now = cpu_irq_in | (|wake_s); // [RULE2]
            ST_STOP0: wake_now = |wake_s; // [RULE18]
            ST_STOP1: wake_now = |wake_s; // [RULE19]
            ST_STOP2: wake_now = |(wake_s & stop2_mask); // [RULE8]
            ST_STBY_RET: wake_now = (|(wake_s & stby_mask)) | pin_edge; // [RULE13]
            ST_STBY: wake_now = (|(wake_s & stby_mask)) | pin_edge; // [RULE13]
            default: wake_now = 1'b0;
        endcase
    end

    // Mode sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (cpu_lp_entry_in && mode_sel != `MODE_RUN && mode_sel != `MODE_RESET) begin
                    next_state = mode_sel; // [RULE1]
                end
            end
            ST_SLEEP, ST_STOP0, ST_STOP2: begin
                if (wake_now) begin
                    next_state = ST_RUN; // [RULE22]
                end else if (state == ST_STOP0 && stop1_parked && !clkreq_s[1]) begin
                    next_state = ST_STOP1;
                end
            end
            ST_STOP1: begin
                if (wake_now) begin
                    next_state = ST_RUN; // [RULE22]
                end else if (clkreq_s[1]) begin
                    next_state = ST_STOP0; // [RULE4]
                end
            end
            ST_STBY_RET, ST_STBY: begin
                if (wake_now) begin
                    next_state = ST_RESET; // [RULE22]
                end
            end
            ST_RESET: begin
                if (rst_cnt == 4'h0) begin
                    next_state = ST_RUN; // [RULE22]
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN; // [RULE1]
            wake_prev <= {`WK_COUNT{1'b0}};
            wake_seen <= {`WK_COUNT{1'b0}};
            rst_cnt <= 4'h0;
            stop1_parked <= 1'b0;
        end else begin
            state <= next_state;
            wake_prev <= wake_s;
            // Event wins over software clear
            wake_seen <= ((reg_wr_in && reg_addr_in == `REG_WAKE_SRC) ?
                wake_seen & ~{6'h0, reg_wdata_in} : wake_seen) |
                (wake_now ? wake_s : {`WK_COUNT{1'b0}});
            if (next_state == ST_RESET && state != ST_RESET) begin
                rst_cnt <= `STBY_RST_CYCLES;
            end else if (rst_cnt != 4'h0) begin
                rst_cnt <= rst_cnt - 4'h1;
            end
            if (state == ST_STOP1 && next_state == ST_STOP0) begin
                stop1_parked <= 1'b1;
            end else if (next_state != ST_STOP0) begin
                stop1_parked <= 1'b0;
            end
        end
    end

    // Register writes; standby wake resets mode, gate and SRAM power settings too
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_sel <= `MODE_RUN;
            ret_cfg <= 5'h00;
            gate_cfg <= 3'h7;
            sram_off <= 2'h0;
            io_ret <= 16'h0000;
        end else if (state == ST_RESET) begin
            mode_sel <= `MODE_RUN;
            gate_cfg <= 3'h7;
            sram_off <= 2'h0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `REG_MODE_SEL: mode_sel <= reg_wdata_in[2:0];
                `REG_RET_CFG: ret_cfg <= reg_wdata_in[4:0];
                `REG_GATE_CFG: gate_cfg <= reg_wdata_in[2:0]; // [RULE20]
                `REG_SRAM_PWR: sram_off <= reg_wdata_in[1:0]; // [RULE21]
                `REG_IO_RET: io_ret[7:0] <= reg_wdata_in;
                `REG_IO_RET_HI: io_ret[15:8] <= reg_wdata_in;
                default: io_ret <= io_ret;
            endcase
        end
    end

    always @* begin
        case (reg_addr_in)
            `REG_MODE_SEL: next_rdata = {5'h00, mode_sel};
            `REG_RET_CFG: next_rdata = {3'h0, ret_cfg};
            `REG_GATE_CFG: next_rdata = {5'h00, gate_cfg};
            `REG_SRAM_PWR: next_rdata = {6'h00, sram_off};
            `REG_STATUS: next_rdata = {3'h0, clkreq_s, state};
            `REG_WAKE_SRC: next_rdata = wake_seen[7:0];
            `REG_IO_RET: next_rdata = io_ret[7:0];
            `REG_IO_RET_HI: next_rdata = io_ret[15:8];
            `REG_WAKE_HI: next_rdata = {2'h0, wake_seen[13:8]};
            default: next_rdata = 8'h00;
        endcase
    end

    // Outputs registered from the next state
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
            cpu_clk_en_out <= 1'b1;
            core_clk_en_out <= 1'b1;
            pll_en_out <= 1'b0;
            internal_16mhz_rc_en_out <= 1'b1;
            crystal_32mhz_osc_en_out <= 1'b0;
            slow_osc_en_out <= 1'b1;
            sysclk_sel_out <= `CLK_RC16;
            sram1_clk_en_out <= 1'b1;
            sram2_clk_en_out <= 1'b1;
            flash_clk_en_out <= 1'b1;
            flash_pwr_en_out <= 1'b1;
            main_reg_en_out <= 1'b1;
            low_power_regulator_state_out <= 1'b0;
            core_domain_pwr_out <= 1'b1;
            sram1_pwr_out <= 1'b1;
            sram2_pwr_out <= 1'b1;
            radio_ret_out <= 1'b0;
            periph_all_pwr_out <= 1'b1;
            periph_stop2_pwr_out <= 1'b1;
            brownout_reset_en_out <= 1'b1;
            brownout_reset_ulp_out <= 1'b0;
            io_retain_out <= 1'b0;
            io_ret_cfg_out <= 16'h0000;
            system_reset_out <= 1'b0;
            mode_out <= `MODE_RUN;
        end else begin
            reg_rdata_out <= reg_rd_in ? next_rdata : 8'h00;
            mode_out <= next_state;
            cpu_clk_en_out <= (next_state == ST_RUN); // [RULE2]
            // Core clocks only in run/sleep, or stop 0 when a bus clock or DMA request is pending
            core_clk_en_out <= (next_state == ST_RUN) || (next_state == ST_SLEEP) ||
                (next_state == ST_STOP0 && (|clkreq_s)); // [RULE3] [RULE18]
            pll_en_out <= (next_state == ST_RUN || next_state == ST_SLEEP) &&
                (sysclk_sel_out == `CLK_PLL); // [RULE3] [RULE9]
            crystal_32mhz_osc_en_out <= (next_state == ST_RUN || next_state == ST_SLEEP) &&
                (sysclk_sel_out == `CLK_XTAL32); // [RULE3] [RULE9]
            // 16 MHz RC on in run, sleep and reset, or on request while stopped [RULE17] [RULE4]
            internal_16mhz_rc_en_out <= (next_state == ST_RUN) || (next_state == ST_SLEEP) ||
                (next_state == ST_RESET) ||
                ((next_state == ST_STOP0 || next_state == ST_STOP1 ||
                next_state == ST_STOP2) && (|clkreq_s));
            slow_osc_en_out <= 1'b1; // [RULE3] [RULE9]
            // Stopped modes park on the RC so every exit resumes on it
            if (next_state != ST_RUN && next_state != ST_SLEEP) begin
                sysclk_sel_out <= `CLK_RC16; // [RULE6] [RULE4]
            end
            sram1_clk_en_out <= gate_cfg[`GATE_SRAM1_BIT]; // [RULE20]
            sram2_clk_en_out <= gate_cfg[`GATE_SRAM2_BIT]; // [RULE20]
            flash_clk_en_out <= gate_cfg[`GATE_FLASH_BIT] &&
                (next_state == ST_RUN || next_state == ST_SLEEP); // [RULE20]
            flash_pwr_en_out <= gate_cfg[`GATE_FLASH_BIT] &&
                (next_state == ST_RUN || next_state == ST_SLEEP); // [RULE20]
            main_reg_en_out <= (next_state == ST_RUN) || (next_state == ST_SLEEP) ||
                (next_state == ST_STOP0) || (next_state == ST_RESET); // [RULE5]
            low_power_regulator_state_out <= (next_state == ST_STOP1) ||
                (next_state == ST_STOP2) || (next_state == ST_STBY_RET); // [RULE5]
            core_domain_pwr_out <= (next_state != ST_STBY) &&
                (next_state != ST_STBY_RET); // [RULE9]
            // SRAM power: retained only where allowed [RULE11] [RULE21]
            case (next_state)
                ST_STBY: begin
                    sram1_pwr_out <= 1'b0;
                    sram2_pwr_out <= 1'b0;
                end
                ST_STBY_RET: begin
                    sram1_pwr_out <= ret_cfg[`RET_SRAM1_BIT] & ~sram_off[0];
                    sram2_pwr_out <= ret_cfg[`RET_SRAM2_BIT] & ~sram_off[1];
                end
                ST_STOP0, ST_STOP1, ST_STOP2: begin
                    sram1_pwr_out <= ~sram_off[0];
                    sram2_pwr_out <= ~sram_off[1];
                end
                default: begin
                    sram1_pwr_out <= 1'b1;
                    sram2_pwr_out <= 1'b1;
                end
            endcase
            radio_ret_out <= (next_state == ST_STBY_RET) && ret_cfg[`RET_RADIO_BIT]; // [RULE12]
            periph_all_pwr_out <= (next_state != ST_STOP2) && (next_state != ST_STBY) &&
                (next_state != ST_STBY_RET); // [RULE7]
            periph_stop2_pwr_out <= (next_state != ST_STBY) &&
                (next_state != ST_STBY_RET); // [RULE7]
            brownout_reset_en_out <= 1'b1; // [RULE10]
            brownout_reset_ulp_out <= ret_cfg[`RET_BOR_ULP_BIT] &&
                (next_state == ST_STOP1 || next_state == ST_STOP2 ||
                next_state == ST_STBY || next_state == ST_STBY_RET); // [RULE16]
            io_retain_out <= (next_state == ST_STBY) || (next_state == ST_STBY_RET); // [RULE15]
            io_ret_cfg_out <= io_ret; // [RULE15]
            system_reset_out <= (next_state == ST_RESET); // [RULE22]
        end
    end
endmodule // low_power_mode_controller

/* verif/lpmc_props.sv */
// Port-level assertions for the low-power mode controller
`include "lp_mode_defs.vh"
module lpmc_props (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Clock and power controls
    input wire cpu_clk_en_out,
    input wire core_clk_en_out,
    input wire pll_en_out,
    input wire internal_16mhz_rc_en_out,
    input wire crystal_32mhz_osc_en_out,
    input wire slow_osc_en_out,
    input wire [1:0] sysclk_sel_out,
    input wire main_reg_en_out,
    input wire low_power_regulator_state_out,
    input wire core_domain_pwr_out,
    input wire periph_all_pwr_out,
    input wire periph_stop2_pwr_out,
    input wire brownout_reset_en_out,
    input wire io_retain_out,
    input wire [2:0] mode_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    bor_always_on_a: assert property (brownout_reset_en_out)
        else $error("brownout monitor switched off");
    sleep_cpu_only_a: assert property (
        mode_out == `MODE_SLEEP |-> !cpu_clk_en_out && core_clk_en_out)
        else $error("sleep clock gating wrong");
    stop_osc_off_a: assert property (
        mode_out inside {`MODE_STOP0, `MODE_STOP1}
        |-> !pll_en_out && !crystal_32mhz_osc_en_out && slow_osc_en_out)
        else $error("oscillators wrong in stop");
    stop0_main_reg_a: assert property (mode_out == `MODE_STOP0 |-> main_reg_en_out)
        else $error("main regulator off in stop 0");
    lp_reg_only_a: assert property (
        mode_out inside {`MODE_STOP1, `MODE_STOP2, `MODE_STBY_RET}
        |-> !main_reg_en_out && low_power_regulator_state_out)
        else $error("regulator choice wrong");
    exit_clk_rc_a: assert property (
        mode_out == `MODE_RUN && $past(mode_out) >= `MODE_STOP0
        |-> sysclk_sel_out == `CLK_RC16)
        else $error("exit clock not the 16 MHz RC");
    stop2_periph_a: assert property (
        mode_out == `MODE_STOP2 |-> !periph_all_pwr_out && periph_stop2_pwr_out)
        else $error("peripheral power wrong in stop 2");
    stby_power_off_a: assert property (
        mode_out == `MODE_STBY |-> !core_domain_pwr_out && !pll_en_out
        && !internal_16mhz_rc_en_out && !crystal_32mhz_osc_en_out && slow_osc_en_out)
        else $error("standby power state wrong");
    stby_io_hold_a: assert property (
        mode_out inside {`MODE_STBY_RET, `MODE_STBY} |-> io_retain_out)
        else $error("io retention missing in standby");
    stby_via_reset_a: assert property (
        mode_out inside {`MODE_STBY_RET, `MODE_STBY} ##1 !(mode_out inside
        {`MODE_STBY_RET, `MODE_STBY}) |-> mode_out == `MODE_RESET)
        else $error("standby left without reset sequence");
    reset_seq_end_a: assert property (
        $rose(mode_out == `MODE_RESET) |-> ##[1:12] mode_out == `MODE_RUN)
        else $error("reset sequence too long");
endmodule // lpmc_props

bind low_power_mode_controller lpmc_props lpmc_props_inst (
    .sys_clk_in, .rstn_in, .cpu_clk_en_out, .core_clk_en_out, .pll_en_out,
    .internal_16mhz_rc_en_out, .crystal_32mhz_osc_en_out, .slow_osc_en_out,
    .sysclk_sel_out, .main_reg_en_out, .low_power_regulator_state_out,
    .core_domain_pwr_out, .periph_all_pwr_out, .periph_stop2_pwr_out,
    .brownout_reset_en_out, .io_retain_out, .mode_out
);

/* verif/periph_model.sv */
// Model of the peripherals raising wake events and clock requests
module periph_model (
    // Clock
    input wire clk_in,
    // Commands from the bench
    input wire [13:0] wake_cmd_in,
    input wire dma_cmd_in,
    // Towards the controller
    output logic [13:0] wake_src_out,
    output logic busclk_req_out,
    output logic dma_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wake_src_out = 14'h0000;
        busclk_req_out = 1'b0;
        dma_req_out = 1'b0;
    end
    // Events land mid-cycle, so the controller's synchroniser is exercised
    always @(negedge clk_in) begin
        wake_src_out <= wake_cmd_in;
        busclk_req_out <= dma_cmd_in;
        dma_req_out <= dma_cmd_in;
    end
endmodule // periph_model

/* verif/low_power_mode_controller_tb.sv */
// Self-checking bench for the low-power mode controller
`include "lp_mode_defs.vh"
module low_power_mode_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [2:0] mode; logic main; logic low_power_regulator_state; int src;} row_t;
    row_t rows [3] = '{'{`MODE_SLEEP, 1'b1, 1'b0, 99},
        '{`MODE_STOP0, 1'b1, 1'b0, `WK_SERIAL1}, '{`MODE_STOP1, 1'b0, 1'b1, `WK_TIM1}};
    int stby_src [5] = '{`WK_RESET_PIN, `WK_INDEPENDENT_WATCHDOG, `WK_PIN, `WK_RTC, `WK_TAMPER_UNIT};
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic cpu_lp_entry_in = 1'b0;
    logic cpu_irq_in = 1'b0;
    logic [13:0] wake_cmd = 14'h0000;
    logic dma_cmd = 1'b0;
    wire [13:0] wake_src;
    wire busclk_req, dma_req, cpu_en, rc16_en, s1_clk, s2_clk, fl_clk, main_en, low_power_regulator_state;
    wire core_pwr, s1_pwr, s2_pwr, ulp, radio_ret, bor_en, io_ret, sys_rst;
    wire [7:0] rdata;
    wire [15:0] io_cfg;
    wire [1:0] sysclk;
    wire [2:0] mode;

    always #10 sys_clk_in = ~sys_clk_in;

    periph_model periph_model_inst (.clk_in(sys_clk_in), .wake_cmd_in(wake_cmd),
        .dma_cmd_in(dma_cmd), .wake_src_out(wake_src), .busclk_req_out(busclk_req),
        .dma_req_out(dma_req));

    low_power_mode_controller low_power_mode_controller_inst (.sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
        .cpu_lp_entry_in(cpu_lp_entry_in), .cpu_irq_in(cpu_irq_in), .wake_src_in(wake_src),
        .stop_busclk_req_in(busclk_req), .stop_dma_req_in(dma_req), .cpu_clk_en_out(cpu_en),
        .core_clk_en_out(), .pll_en_out(), .internal_16mhz_rc_en_out(rc16_en),
        .crystal_32mhz_osc_en_out(), .slow_osc_en_out(), .sysclk_sel_out(sysclk),
        .sram1_clk_en_out(s1_clk), .sram2_clk_en_out(s2_clk), .flash_clk_en_out(fl_clk),
        .flash_pwr_en_out(), .main_reg_en_out(main_en), .low_power_regulator_state_out(low_power_regulator_state),
        .core_domain_pwr_out(core_pwr), .sram1_pwr_out(s1_pwr), .sram2_pwr_out(s2_pwr),
        .radio_ret_out(radio_ret), .periph_all_pwr_out(), .periph_stop2_pwr_out(),
        .brownout_reset_en_out(bor_en), .brownout_reset_ulp_out(ulp), .io_retain_out(io_ret),
        .io_ret_cfg_out(io_cfg), .system_reset_out(sys_rst), .mode_out(mode));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic wait_mode(input logic [2:0] m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge sys_clk_in);
            #1 n++;
        end
        chk(mode, m);
    endtask

    task automatic enter(input logic [2:0] m);
        wr(4'h0, {5'h00, m});
        @(posedge sys_clk_in);
        cpu_lp_entry_in <= 1'b1;
        @(posedge sys_clk_in);
        cpu_lp_entry_in <= 1'b0;
        wait_mode(m, 8);
    endtask

    // Source index above 13 means the processor interrupt
    task automatic wake(input int s, input logic [2:0] m, input int lim);
        @(posedge sys_clk_in);
        if (s > 13) cpu_irq_in <= 1'b1;
        else wake_cmd[s] <= 1'b1;
        wait_mode(m, lim);
        @(posedge sys_clk_in);
        wake_cmd <= 14'h0000;
        cpu_irq_in <= 1'b0;
    endtask

    // No fixed latency to wait for when nothing should happen
    task automatic nowake(input int s, input logic [2:0] m);
        @(posedge sys_clk_in);
        wake_cmd[s] <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        #1 chk(mode, m);
        wake_cmd <= 14'h0000;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        #1 chk(mode, `MODE_RUN);
        chk(cpu_en, 1'b1);
        chk(bor_en, 1'b1);
        rd(4'h2, 8'h07);
        rd(4'hF, 8'h00);
        wr(4'h6, 8'hA5);
        wr(4'h7, 8'h3C);
        wr(4'h2, 8'h02);
        repeat (2) @(posedge sys_clk_in);
        #1 chk({s1_clk, s2_clk, fl_clk}, 3'b010);
        chk(io_cfg, 16'h3CA5);
        rd(4'h7, 8'h3C);
        wr(4'h2, 8'h07);
        foreach (rows[i]) begin
            enter(rows[i].mode);
            chk(cpu_en, 1'b0);
            chk(main_en, rows[i].main);
            chk(low_power_regulator_state, rows[i].low_power_regulator_state);
            wake(rows[i].src, `MODE_RUN, 10);
            chk(sysclk, `CLK_RC16);
        end
        enter(`MODE_STOP2);
        nowake(`WK_OTHER, `MODE_STOP2);
        wake(`WK_TIM1, `MODE_RUN, 10);
        for (int s = 0; s < 12; s++) begin
            enter(`MODE_STOP2);
            wake(s, `MODE_RUN, 10);
        end
        enter(`MODE_STOP1);
        @(posedge sys_clk_in);
        dma_cmd <= 1'b1;
        wait_mode(`MODE_STOP0, 10);
        chk(rc16_en, 1'b1);
        @(posedge sys_clk_in);
        dma_cmd <= 1'b0;
        wait_mode(`MODE_STOP1, 10);
        wake(`WK_TIM1, `MODE_RUN, 10);
        foreach (stby_src[i]) begin
            enter(`MODE_STBY);
            chk(core_pwr, 1'b0);
            chk(io_ret, 1'b1);
            if (i == 0) nowake(`WK_RSC, `MODE_STBY);
            wake(stby_src[i], `MODE_RESET, 10);
            chk(sys_rst, 1'b1);
            wait_mode(`MODE_RUN, 12);
            chk(sysclk, `CLK_RC16);
        end
        wr(4'h1, 8'h0F);
        wr(4'h3, 8'h02);
        enter(`MODE_STBY_RET);
        chk(s1_pwr, 1'b1);
        chk(s2_pwr, 1'b0);
        chk(ulp, 1'b1);
        chk(radio_ret, 1'b1);
        chk(low_power_regulator_state, 1'b1);
        wake(`WK_RSC, `MODE_RESET, 10);
        wait_mode(`MODE_RUN, 12);
        conclude();
    end
endmodule // low_power_mode_controller_tb
